/* File: src/vic_pkg.sv */
`default_nettype none
package vic_pkg;
  localparam int NUM_SRC = 24;
  localparam int NUM_GRP = 6;
  localparam int NUM_EXT = 6;
  // Register byte offsets.
  localparam logic [7:0] OFS_ENABLE_A   = 8'h00;
  localparam logic [7:0] OFS_ENABLE_B   = 8'h04;
  localparam logic [7:0] OFS_ENABLE_C   = 8'h08;
  localparam logic [7:0] OFS_ENABLE_D   = 8'h0c;
  localparam logic [7:0] OFS_PRIO_LOW   = 8'h10;
  localparam logic [7:0] OFS_PRIO_HIGH  = 8'h14;
  localparam logic [7:0] OFS_POL_LOW    = 8'h18;
  localparam logic [7:0] OFS_POL_SECOND = 8'h1c;
  localparam logic [7:0] OFS_EXT_PEND   = 8'h20;
  localparam logic [7:0] OFS_POWER_CTL  = 8'h24;
  localparam logic [7:0] OFS_REQ_FLAGS  = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h30;
  localparam logic [7:0] OFS_EXT_ENABLE = 8'h34;
  // Field positions and reset values.
  localparam int GATE_BIT  = 7;
  localparam int PWR_IDLE  = 0;
  localparam int PWR_STOP  = 1;
  localparam int EV_ACCEPT = 0;
  localparam int EV_WAKE   = 1;
  localparam int EV_EXT    = 2;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [23:0] RST_FLAGS = 24'h000000;
  // Vector layout.
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam int          VEC_SHIFT = 3;
  // Internal sources that exist; of the others only 0, 1 and 5 raise a flag, from the external lines.
  localparam logic [23:0] INTERNAL_SRC = 24'h7c71c4;
  localparam int SRC_EXT_A    = 0;
  localparam int SRC_EXT_B    = 1;
  localparam int SRC_EXT_SHR  = 5;
  localparam int LINE_EXT_A   = 4;
  localparam int LINE_EXT_B   = 5;
  // Polarity codes, two bits per line.
  localparam logic [1:0] POL_OFF = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;
  localparam logic [1:0] POL_BOTH = 2'h3;

  typedef enum {ST_IDLE, ST_PRESENT, ST_CALL} svc_state_e;

  typedef struct packed {
    logic        req;
    logic [4:0]  src;
    logic [15:0] vector;
  } cpu_req_s;
endpackage : vic_pkg
`default_nettype wire

/* File: src/vectored_interrupt_controller.sv */
// Behaviour
// - group level from low and high select bits
// - higher level request is handed first
// - six external lines with polarity and enables
// - readable pending register for external lines
// - any enabled source raises wake-up
// - hold servicing during protected register writes
// - vector supplied for CPU long call
// - 24 sources, fixed order, lower group then lower source wins ties
// - reset vector zero, sources step eight bytes
// - four enable registers, six bits each
// - service needs global and own enable
// - request flag set until CPU accepts
// - flag cleared by hardware on acceptance
// - six groups, group zero ranks highest
// - gate cleared on entry, set on return
// - request to vector within few cycles
//
// Our own choices: the APB slave port and the address map.
`default_nettype none
module vectored_interrupt_controller
  import vic_pkg::*;
(
  input  wire logic        REF_CLK,        // System clock.
  input  wire logic        RESET,          // Synchronous reset, active high.
  input  wire logic        PSEL,           // APB select.
  input  wire logic        PENABLE,        // APB access phase.
  input  wire logic        PWRITE,         // APB direction.
  input  wire logic [7:0]  PADDR,          // APB byte address.
  input  wire logic [31:0] PWDATA,         // APB write data.
  output logic      [31:0] PRDATA,         // APB read data.
  output logic             PREADY,         // APB ready.
  output logic             PSLVERR,        // APB error on unmapped address.
  input  wire logic [5:0]  EXT_PIN,        // External interrupt lines.
  input  wire logic [23:0] PERIPH_REQ,     // Peripheral request pulses.
  input  wire logic        INSTR_BOUNDARY, // CPU at an instruction boundary.
  input  wire logic        CPU_ACK,        // CPU accepts the presented vector.
  input  wire logic        CALL_DONE,      // CPU finished the long call.
  input  wire logic        HANDLER_RETURN, // CPU executed return from handler.
  output cpu_req_s         CPU_REQ,        // Request, source and vector.
  output logic             WAKE,           // Release from STOP and IDLE.
  output logic             IRQ_OUT         // Status interrupt line.
);

  logic [7:0]  enable_r [4];
  logic [5:0]  prio_low_r;
  logic [5:0]  prio_high_r;
  logic [7:0]  pol_low_r;
  logic [3:0]  pol_second_r;
  logic [5:0]  ext_enable_r;
  logic [5:0]  ext_pend_r;
  logic [5:0]  pin_prev_r;
  logic [1:0]  power_r;
  logic [23:0] flag_r;
  logic [2:0]  stat_r;
  logic [2:0]  mask_r;
  logic        hold_r;
  logic        wake_r;
  svc_state_e  state_r;
  cpu_req_s    req_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  logic        wr_en;
  logic [5:0]  ext_hit;
  logic [5:0]  ext_pol [2];
  logic [23:0] flag_set;
  logic [23:0] flag_clr;
  logic [23:0] src_en;
  logic [23:0] eligible;
  logic        found;
  logic [4:0]  win_src;
  logic        accept;
  logic        prot_wr;

  // Address decode shared by the write enable and the error response logic.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_EXT_ENABLE);
  endfunction

  function automatic logic protected_reg(input logic [7:0] a);
    protected_reg = (a == OFS_ENABLE_A) || (a == OFS_ENABLE_B) || (a == OFS_ENABLE_C) ||
                    (a == OFS_ENABLE_D) || (a == OFS_PRIO_LOW) || (a == OFS_PRIO_HIGH) ||
                    (a == OFS_POWER_CTL);
  endfunction

  // Vector of a source: base plus eight bytes per source.
  function automatic logic [15:0] vector_of(input logic [4:0] s);
    vector_of = VEC_BASE + {8'h00, s, 3'h0};
  endfunction

  assign wr_en   = PSEL && PENABLE && pready_r && PWRITE && mapped(PADDR);
  assign prot_wr = PSEL && PWRITE && protected_reg(PADDR);
  assign accept  = (state_r == ST_PRESENT) && CPU_ACK;

  // Per-source enable: four registers of six bits each.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_en
      assign src_en[gi] = enable_r[gi / NUM_GRP][gi % NUM_GRP];
    end
  endgenerate

  assign eligible = flag_r & src_en & {NUM_SRC{enable_r[0][GATE_BIT]}};

  // Polarity code per line, lines 0-3 in the low register, 4-5 in the second.
  always_comb
  begin
    ext_pol[0] = '0;
    ext_pol[1] = '0;
    for (int i = 0; i < NUM_EXT; i++)
    begin
      logic [1:0] code;
      code = 2'({pol_second_r, pol_low_r} >> (2 * i));
      ext_pol[0][i] = code[0];
      ext_pol[1][i] = code[1];
    end
  end

  // Edge detection per line according to its polarity and enable.
  assign ext_hit = ext_enable_r & ((ext_pol[0] & EXT_PIN & ~pin_prev_r) |
                                   (ext_pol[1] & ~EXT_PIN & pin_prev_r));

  // Request flag set terms for the sources that exist.
  always_comb
  begin
    flag_set = PERIPH_REQ & INTERNAL_SRC;
    flag_set[SRC_EXT_A]   = ext_hit[LINE_EXT_A];
    flag_set[SRC_EXT_B]   = ext_hit[LINE_EXT_B];
    flag_set[SRC_EXT_SHR] = |ext_hit[3:0];
    flag_clr = '0;
    if (accept)
    begin
      flag_clr[req_r.src] = 1'b1;
    end
  end

  // Arbitration: level 3 first, then group 0 first, then lowest source in group.
  always_comb
  begin
    found   = 1'b0;
    win_src = '0;
    for (int lv = 3; lv >= 0; lv--)
    begin
      for (int g = 0; g < NUM_GRP; g++)
      begin
        for (int k = 0; k < 4; k++)
        begin
          if (!found && eligible[g + NUM_GRP * k] &&
              ({prio_high_r[g], prio_low_r[g]} == 2'(lv)))
          begin
            found   = 1'b1;
            win_src = 5'(g + NUM_GRP * k);
          end
        end
      end
    end
  end

  // Request flags: set wins over the acceptance clear, reset clears all.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      flag_r <= RST_FLAGS;
    else
      flag_r <= (flag_r & ~flag_clr) | flag_set;
  end

  // Line history follows the pins through reset, so a line idling high shows no false edge after it.
  always_ff @(posedge REF_CLK)
  begin
    pin_prev_r <= EXT_PIN;
    if (RESET)
      ext_pend_r <= '0;
    else
      ext_pend_r <= (ext_pend_r & ~((wr_en && PADDR == OFS_EXT_PEND) ? PWDATA[5:0] : 6'h00)) |
                    ext_hit;
  end

  // Enable registers; the global gate is cleared on entry and set on return.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      for (int i = 0; i < 4; i++)
        enable_r[i] <= RST_BYTE;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        if (wr_en && PADDR == OFS_ENABLE_A + 8'(4 * i))
          enable_r[i] <= {(i == 0) ? PWDATA[GATE_BIT] : 1'b0, 1'b0, PWDATA[5:0]};
      if (accept)
        enable_r[0][GATE_BIT] <= 1'b0;
      else if (HANDLER_RETURN)
        enable_r[0][GATE_BIT] <= 1'b1;
    end
  end

  // Priority, polarity and line enable registers take effect next cycle.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      prio_low_r   <= '0;
      prio_high_r  <= '0;
      pol_low_r    <= '0;
      pol_second_r <= '0;
      ext_enable_r <= '0;
    end
    else if (wr_en)
    begin
      if (PADDR == OFS_PRIO_LOW)   prio_low_r   <= PWDATA[5:0];
      if (PADDR == OFS_PRIO_HIGH)  prio_high_r  <= PWDATA[5:0];
      if (PADDR == OFS_POL_LOW)    pol_low_r    <= PWDATA[7:0];
      if (PADDR == OFS_POL_SECOND) pol_second_r <= PWDATA[3:0];
      if (PADDR == OFS_EXT_ENABLE) ext_enable_r <= PWDATA[5:0];
    end
  end

  // Power control: software requests a mode, a wake-up ends it.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      power_r <= '0;
    else if (wake_r)
      power_r <= '0;
    else if (wr_en && PADDR == OFS_POWER_CTL)
      power_r <= PWDATA[1:0];
  end

  // Wake-up from any flagged source with its own enable, priority ignored.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      wake_r <= 1'b0;
    else
      wake_r <= |(flag_r & src_en);
  end

  // Servicing is held for the cycle after any protected register write.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      hold_r <= 1'b0;
    else
      hold_r <= prot_wr;
  end

  // Service sequence: present at a boundary, wait for acceptance, then the call.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state_r <= ST_IDLE;
      req_r   <= '{req: 1'b0, src: 5'h00, vector: VEC_RESET};
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (found && INSTR_BOUNDARY && !hold_r && !prot_wr)
          begin
            state_r <= ST_PRESENT;
            req_r   <= '{req: 1'b1, src: win_src, vector: vector_of(win_src)};
          end
        end
        ST_PRESENT:
        begin
          if (CPU_ACK)
          begin
            state_r   <= ST_CALL;
            req_r.req <= 1'b0;
          end
        end
        ST_CALL:
        begin
          if (CALL_DONE)
            state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Status events: sticky, set wins over a write-one clear.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      stat_r <= '0;
      mask_r <= '0;
    end
    else
    begin
      stat_r <= (stat_r & ~((wr_en && PADDR == OFS_IRQ_STAT) ? PWDATA[2:0] : 3'h0)) |
                {|ext_hit, wake_r && (power_r != 2'h0), accept};
      if (wr_en && PADDR == OFS_IRQ_MASK)
        mask_r <= PWDATA[2:0];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      IRQ_OUT <= 1'b0;
    else
      IRQ_OUT <= |(stat_r & mask_r);
  end

  // APB slave: one wait-free access phase, data prepared in the setup cycle.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
    else
    begin
      pready_r  <= PSEL && !PENABLE;
      pslverr_r <= PSEL && !PENABLE && !mapped(PADDR);
      prdata_r  <= '0;
      if (PSEL && !PENABLE && !PWRITE)
      begin
        unique case (PADDR)
          OFS_ENABLE_A:   prdata_r <= {24'h0, enable_r[0]};
          OFS_ENABLE_B:   prdata_r <= {24'h0, enable_r[1]};
          OFS_ENABLE_C:   prdata_r <= {24'h0, enable_r[2]};
          OFS_ENABLE_D:   prdata_r <= {24'h0, enable_r[3]};
          OFS_PRIO_LOW:   prdata_r <= {26'h0, prio_low_r};
          OFS_PRIO_HIGH:  prdata_r <= {26'h0, prio_high_r};
          OFS_POL_LOW:    prdata_r <= {24'h0, pol_low_r};
          OFS_POL_SECOND: prdata_r <= {28'h0, pol_second_r};
          OFS_EXT_PEND:   prdata_r <= {26'h0, ext_pend_r};
          OFS_POWER_CTL:  prdata_r <= {30'h0, power_r};
          OFS_REQ_FLAGS:  prdata_r <= {8'h0, flag_r};
          OFS_IRQ_STAT:   prdata_r <= {29'h0, stat_r};
          OFS_IRQ_MASK:   prdata_r <= {29'h0, mask_r};
          OFS_EXT_ENABLE: prdata_r <= {26'h0, ext_enable_r};
          default:        prdata_r <= '0;
        endcase
      end
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  assign CPU_REQ = req_r;
  assign WAKE    = wake_r;

endmodule // vectored_interrupt_controller
`default_nettype wire

/* File: bench/vic_monitor.sv */
`default_nettype none
// Watches the bus handshake and the vector hand-off to the core.
module vic_monitor
  import vic_pkg::*;
(
  input wire logic        REF_CLK,        // Clock.
  input wire logic        RESET,          // Reset.
  input wire logic        PSEL,           // Select.
  input wire logic        PENABLE,        // Access.
  input wire logic        PWRITE,         // Write.
  input wire logic [7:0]  PADDR,          // Address.
  input wire logic [31:0] PRDATA,         // Read data.
  input wire logic        PREADY,         // Ready.
  input wire logic        PSLVERR,        // Error.
  input wire logic        INSTR_BOUNDARY, // Boundary.
  input wire logic        CPU_ACK,        // Accept.
  input wire cpu_req_s    CPU_REQ         // Vector.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // A write to an enable, priority or power register on the bus.
  wire logic prot_wr = PSEL && PWRITE && (PADDR <= OFS_PRIO_HIGH || PADDR == OFS_POWER_CTL);

  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("No ready after setup.");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("Ready outside access.");
  a_err_reads_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("Bad error response.");
  a_req_stands: assert property (CPU_REQ.req && !CPU_ACK |=> CPU_REQ.req && $stable(CPU_REQ.src))
    else $error("Request dropped before accept.");
  a_req_drops: assert property (CPU_REQ.req && CPU_ACK |=> !CPU_REQ.req)
    else $error("Request stays after accept.");
  a_vector_map: assert property (CPU_REQ.req |-> CPU_REQ.vector == VEC_BASE + (16'(CPU_REQ.src) << VEC_SHIFT))
    else $error("Vector does not match source.");
  a_src_range: assert property (CPU_REQ.req |-> CPU_REQ.src < 5'd24)
    else $error("Source out of range.");
  a_at_boundary: assert property ($rose(CPU_REQ.req) |-> $past(INSTR_BOUNDARY))
    else $error("Request off a boundary.");
  a_write_holds: assert property ($rose(CPU_REQ.req) |-> !$past(prot_wr) && !$past(prot_wr, 2))
    else $error("Request during protected write.");
endmodule // vic_monitor

bind vectored_interrupt_controller vic_monitor mon (
  .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .INSTR_BOUNDARY(INSTR_BOUNDARY),
  .CPU_ACK(CPU_ACK), .CPU_REQ(CPU_REQ));
`default_nettype wire

/* File: bench/cpu_core_model.sv */
`default_nettype none
// Core model: takes each vector, runs the long call, later returns.
module cpu_core_model
  import vic_pkg::*;
(
  input  wire logic       clk,      // Clock.
  input  wire logic       rst,      // Reset.
  input  wire cpu_req_s   req_in,   // Presented vector.
  input  wire logic       stall,    // Stay off boundaries.
  input  wire logic [3:0] lat,      // Answer delay.
  output logic            boundary, // At a boundary.
  output logic            ack,      // Vector taken.
  output logic            done,     // Call finished.
  output logic            ret       // Handler returned.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] taken[$];
  int         ph = 0;
  int         cnt = 0;
  assign boundary = !stall;
  // Accept after lat cycles, end the call, return after lat more.
  always @(posedge clk)
  begin
    ack <= 1'b0;
    done <= 1'b0;
    ret <= 1'b0;
    cnt <= (ph == 0 && !req_in.req) ? 0 : cnt + 1;
    if (rst)
      ph <= 0;
    else if (ph == 0 && req_in.req && cnt >= lat)
    begin
      ack <= 1'b1;
      taken.push_back(req_in.src);
      ph <= 1;
    end
    else if (ph == 1)
    begin
      done <= 1'b1;
      ph <= 2;
      cnt <= 0;
    end
    else if (ph == 2 && cnt >= lat)
    begin
      ret <= 1'b1;
      ph <= 0;
      cnt <= 0;
    end
  end
endmodule // cpu_core_model
`default_nettype wire

/* File: bench/vectored_interrupt_controller_tb_top.sv */
`default_nettype none
module vectored_interrupt_controller_tb_top
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [5:0]  ext_pin = 6'h02;
  logic [23:0] periph = 24'h0;
  logic [3:0]  lat = 4'd1;
  logic        boundary, ack, done, ret, pready, pslverr, wake, irq;
  cpu_req_s    cpu_req;
  int          fail_count = 0, total_checks = 0, nt = 0;
  int          used[12] = '{2, 6, 7, 8, 12, 13, 14, 18, 19, 20, 21, 22};

  always #2.5 clk = ~clk;

  vectored_interrupt_controller dut (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_PIN(ext_pin), .PERIPH_REQ(periph), .INSTR_BOUNDARY(boundary), .CPU_ACK(ack), .CALL_DONE(done),
    .HANDLER_RETURN(ret), .CPU_REQ(cpu_req), .WAKE(wake), .IRQ_OUT(irq));
  cpu_core_model cpu (.clk(clk), .rst(rst), .req_in(cpu_req), .stall(stall), .lat(lat),
    .boundary(boundary), .ack(ack), .done(done), .ret(ret));

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus transfer with an idle cycle after it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      check("ready", 32'h0, 32'h1);
      complete_run();
    end
    @(posedge clk);
  endtask

  // Waits until the core has taken k vectors and is back in its main flow.
  task automatic wait_log(input int k);
    int n;
    for (n = 0; n < 400 && (cpu.taken.size() < k || cpu.ph != 0); n++)
      @(posedge clk);
    if (n >= 400)
    begin
      check("vector wait", 32'h0, 32'h1);
      complete_run();
    end
  endtask

  task automatic pulse(input logic [23:0] m);
    periph <= m;
    @(posedge clk);
    periph <= 24'h0;
    @(posedge clk);
  endtask

  // Four pending sources released at once; ex holds the expected order, first in the low bits.
  task automatic burst(input logic [31:0] lo, input logic [31:0] hi, input logic [19:0] ex);
    apb(1'b1, OFS_ENABLE_A, 32'h04);
    apb(1'b1, OFS_PRIO_LOW, lo);
    apb(1'b1, OFS_PRIO_HIGH, hi);
    pulse(24'h003104);
    stall <= 1'b1;
    apb(1'b1, OFS_ENABLE_A, 32'h84);
    repeat (8) @(posedge clk);
    check("held req", 32'(cpu_req.req), 32'h0);
    stall <= 1'b0;
    apb(1'b1, OFS_PRIO_HIGH, hi);
    @(posedge clk);
    check("write hold", 32'(cpu_req.req), 32'h0);
    wait_log(nt + 4);
    for (int j = 0; j < 4; j++)
      check("order", 32'(cpu.taken[nt + j]), 32'(ex[5 * j +: 5]));
    nt += 4;
    $display("Test burst done");
  endtask

  initial
  begin
    int s;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Every register reads zero after reset; an unmapped word is refused.
    for (int a = 0; a <= 'h34; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      check("reset reg", rd, 32'h0);
    end
    check("reset req", 32'(cpu_req), 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    apb(1'b1, OFS_POWER_CTL, 32'h2);
    apb(1'b0, OFS_POWER_CTL, 32'h0);
    check("power mode", rd, 32'h2);
    $display("Test reset done");
    // Each used source alone reaches the core and its flag clears.
    foreach (used[i])
    begin
      s = used[i];
      apb(1'b1, 8'(4 * (s / 6)), 32'h1 << (s % 6));
      apb(1'b1, OFS_ENABLE_A, (s < 6) ? (32'h80 | (32'h1 << s)) : 32'h80);
      pulse(24'h1 << s);
      @(posedge clk);
      check("latency", 32'(cpu_req.req), 32'h1);
      wait_log(nt + 1);
      check("source", 32'(cpu.taken[nt]), 32'(s));
      check("vector", 32'(cpu_req.vector), 32'(VEC_BASE) + 32'(8 * s));
      nt++;
      apb(1'b0, OFS_REQ_FLAGS, 32'h0);
      check("flags clear", rd, 32'h0);
      apb(1'b1, 8'(4 * (s / 6)), 32'h0);
    end
    pulse(24'h800008);
    apb(1'b0, OFS_REQ_FLAGS, 32'h0);
    check("unused src", rd, 32'h0);
    $display("Test sources done");
    // Gate closed: flags stay, nothing is served, wake still follows the enable.
    apb(1'b1, OFS_ENABLE_A, 32'h0);
    apb(1'b1, OFS_ENABLE_B, 32'h04);
    apb(1'b1, OFS_ENABLE_C, 32'h03);
    pulse(24'h003000);
    apb(1'b0, OFS_REQ_FLAGS, 32'h0);
    check("sticky flags", rd, 32'h003000);
    check("gate closed", 32'(cpu.taken.size()), 32'(nt));
    check("wake", 32'(wake), 32'h1);
    $display("Test gate done");
    burst(32'h02, 32'h0, {5'd8, 5'd2, 5'd12, 5'd13});
    lat <= 4'd6;
    burst(32'h01, 32'h05, {5'd13, 5'd8, 5'd2, 5'd12});
    // External lines: line 0 on rising, line 1 on falling edges.
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check("wake status", rd, 32'h3);
    apb(1'b0, OFS_POWER_CTL, 32'h0);
    check("power cleared", rd, 32'h0);
    check("irq masked", 32'(irq), 32'h0);
    apb(1'b1, OFS_EXT_ENABLE, 32'h03);
    apb(1'b1, OFS_POL_LOW, {28'h0, POL_FALL, POL_RISE});
    apb(1'b1, OFS_IRQ_MASK, 32'h04);
    ext_pin <= 6'h01;
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_EXT_PEND, 32'h0);
    check("ext pending", rd, 32'h03);
    check("irq raised", 32'(irq), 32'h1);
    apb(1'b1, OFS_EXT_PEND, 32'h03);
    apb(1'b1, OFS_IRQ_STAT, 32'h04);
    apb(1'b0, OFS_EXT_PEND, 32'h0);
    check("ext cleared", rd, 32'h0);
    check("irq cleared", 32'(irq), 32'h0);
    // Lines 4 and 5 feed sources 0 and 1: line 4 on both edges, line 5 on rising only.
    apb(1'b1, OFS_EXT_ENABLE, 32'h33);
    apb(1'b1, OFS_POL_SECOND, {28'h0, POL_RISE, POL_BOTH});
    ext_pin <= 6'h31;
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_REQ_FLAGS, 32'h0);
    check("ext sources", rd, 32'h000023);
    apb(1'b1, OFS_EXT_PEND, 32'h30);
    ext_pin <= 6'h01;
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_EXT_PEND, 32'h0);
    check("ext polarity", rd, 32'h10);
    $display("Test external done");
    complete_run();
  end
endmodule // vectored_interrupt_controller_tb_top
`default_nettype wire
